// ---- design/ipc_consts.svh ----
// Register offsets, field positions, reset values and masks of the priority block
`ifndef IPC_CONSTS_SVH
`define IPC_CONSTS_SVH

// Byte offsets on the register bus
`define IPC_OFF_CTRL2 8'h00
`define IPC_OFF_SER3 8'h04
`define IPC_OFF_PRIO20 8'h08
`define IPC_OFF_EXTPRIO 8'h0C
`define IPC_OFF_EXTFLAG 8'h10
`define IPC_OFF_PRESENT 8'h14

// Interrupt control two fields
`define IPC_CTRL2_ALTVEC_BIT 15
`define IPC_CTRL2_HOLD_BIT 14
`define IPC_CTRL2_WMASK 32'h0000801F
`define IPC_CTRL2_RESET 32'h00000000

// Priority field lower bit positions
`define IPC_SER3_TX_POS 12
`define IPC_SER3_RX_POS 8
`define IPC_SER3_ERR_POS 4
`define IPC_P20_SPIEV_POS 12
`define IPC_P20_SPIFLT_POS 8
`define IPC_P20_U4TX_POS 4
`define IPC_P20_U4RX_POS 0
`define IPC_EXTPRIO_STRIDE 4

// Reset values and writable masks
`define IPC_SER3_RESET 32'h00004440
`define IPC_SER3_WMASK 32'h00007770
`define IPC_PRIO20_RESET 32'h00004444
`define IPC_PRIO20_WMASK 32'h00007777
`define IPC_EXTPRIO_RESET 32'h00044444
`define IPC_EXTPRIO_WMASK 32'h00077777
`define IPC_EXTFLAG_MASK 32'h0000001F

// Present register fields
`define IPC_PRESENT_VALID_BIT 8
`define IPC_PRESENT_LEVEL_POS 4

// Cycles after reset before pin edges are believed
`define IPC_SYNC_SETTLE 2'h3

`endif

// ---- design/ipc_pkg.sv ----
// Types shared by the priority block and its arbiter
package ipc_pkg;

    typedef logic [2:0] ipc_prio_t;

    typedef enum logic [3:0] {
        IPC_SRC_EXT0 = 4'h0,
        IPC_SRC_EXT1 = 4'h1,
        IPC_SRC_EXT2 = 4'h2,
        IPC_SRC_EXT3 = 4'h3,
        IPC_SRC_EXT4 = 4'h4,
        IPC_SRC_SER3_TX = 4'h5,
        IPC_SRC_SER3_RX = 4'h6,
        IPC_SRC_SER3_ERR = 4'h7,
        IPC_SRC_SPI3_EV = 4'h8,
        IPC_SRC_SPI3_FLT = 4'h9,
        IPC_SRC_SER4_TX = 4'hA,
        IPC_SRC_SER4_RX = 4'hB
    } ipc_src_t;

endpackage

// ---- design/ipc_arb_if.sv ----
// Requests and priorities to the arbiter, winner back
`timescale 1ns/1ps
`default_nettype none

interface ipc_arb_if #(
    parameter int NSRC = 12
);
    logic [NSRC-1:0] req;
    ipc_pkg::ipc_prio_t [NSRC-1:0] prio;
    logic win_valid;
    logic [3:0] win_id;
    ipc_pkg::ipc_prio_t win_level;

    modport ctrl (output req, output prio, input win_valid, input win_id, input win_level);
    modport arb (input req, input prio, output win_valid, output win_id, output win_level);
endinterface

`default_nettype wire

// ---- design/ipc_arbiter.sv ----
// Combinational highest-priority pick among pending sources
`timescale 1ns/1ps
`default_nettype none

module ipc_arbiter #(
    parameter int NSRC = 12
) (
    // Requests in, winner out
    ipc_arb_if.arb arb
);

    // Strictly greater keeps the lowest index on a tie
    always_comb
    begin
        arb.win_valid = 1'b0;
        arb.win_id = 4'h0;
        arb.win_level = 3'h0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (arb.req[i] && (arb.prio[i] > arb.win_level))
            begin
                arb.win_valid = 1'b1;
                arb.win_id = 4'(i);
                arb.win_level = arb.prio[i];
            end
        end
    end

endmodule

`default_nettype wire

// ---- design/ipc_top.sv ----
// Interrupt priority and edge configuration block with Wishbone register access
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.svh"

// What this block does
// - Five external inputs, polarity bit n per input
// - Bit one selects falling edge, zero rising
// - Three-bit priorities; 111 highest, 000 disables source
// - Unimplemented bits read zero, writes ignored
module ipc_top #(
    parameter int NEXT = 5,
    parameter int NPER = 7
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External interrupt pins, asynchronous
    input wire logic [NEXT-1:0] ext_irq_pin,
    // Peripheral requests, same clock, level
    input wire logic [NPER-1:0] periph_irq_req,
    // Core side
    input wire logic irq_hold_active,
    input wire logic cpu_irq_ack,
    output logic cpu_irq_req,
    output logic [3:0] cpu_irq_id,
    output logic [2:0] cpu_irq_level,
    output logic alternate_vector_select,
    output logic [NEXT-1:0] ext_irq_edge
);

    localparam int NSRC = NEXT + NPER;

    // Byte-lane merge limited to the writable bits
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel,
        input logic [31:0] wmask
    );
        logic [31:0] lanes;
        lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
        return (old_v & ~lanes) | (new_v & lanes);
    endfunction

    // Pull one priority field from a register image
    function automatic ipc_pkg::ipc_prio_t prio_field(
        input logic [31:0] reg_v,
        input int pos
    );
        return ipc_pkg::ipc_prio_t'(reg_v >> pos);
    endfunction

    // Register images
    logic [31:0] ctrl2_q;
    logic [31:0] ser3_q;
    logic [31:0] prio20_q;
    logic [31:0] extprio_q;
    logic [NEXT-1:0] ext_flag_q;
    logic [NEXT-1:0] ext_flag_d;

    // Bus handshake
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Pin synchronisers and edge detect
    logic [NEXT-1:0] pin_meta_q;
    logic [NEXT-1:0] pin_sync_q;
    logic [NEXT-1:0] pin_prev_q;
    logic [1:0] settle_q;
    logic edge_armed;
    logic [NEXT-1:0] pin_rise;
    logic [NEXT-1:0] pin_fall;
    logic [NEXT-1:0] pin_edge;
    logic [NEXT-1:0] edge_q;

    // Presented request
    logic irq_req_q;
    logic [3:0] irq_id_q;
    logic [2:0] irq_level_q;
    logic [NEXT-1:0] ack_clear;
    logic [NEXT-1:0] sw_clear;

    ipc_arb_if #(.NSRC(NSRC)) arb_bus ();

    ipc_arbiter #(
        .NSRC(NSRC)
    ) u_arbiter (
        .arb(arb_bus)
    );

    // A request is served in the cycle after it appears, ack drops the next
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign bus_wr = bus_req && wb_we_i;
    assign bus_rd = bus_req && !wb_we_i;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            ack_q <= 1'b0;
        else
            ack_q <= bus_req;
    end

    // Interrupt control two: vector select and polarity bits are writable
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            ctrl2_q <= `IPC_CTRL2_RESET;
        else if (bus_wr && wb_adr_i == `IPC_OFF_CTRL2)
            ctrl2_q <= lane_merge(ctrl2_q, wb_dat_i, wb_sel_i, `IPC_CTRL2_WMASK);
    end

    // Serial port three priorities
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            ser3_q <= `IPC_SER3_RESET;
        else if (bus_wr && wb_adr_i == `IPC_OFF_SER3)
            ser3_q <= lane_merge(ser3_q, wb_dat_i, wb_sel_i, `IPC_SER3_WMASK);
    end

    // SPI three and serial port four priorities
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            prio20_q <= `IPC_PRIO20_RESET;
        else if (bus_wr && wb_adr_i == `IPC_OFF_PRIO20)
            prio20_q <= lane_merge(prio20_q, wb_dat_i, wb_sel_i, `IPC_PRIO20_WMASK);
    end

    // External input priorities, one nibble each
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            extprio_q <= `IPC_EXTPRIO_RESET;
        else if (bus_wr && wb_adr_i == `IPC_OFF_EXTPRIO)
            extprio_q <= lane_merge(extprio_q, wb_dat_i, wb_sel_i, `IPC_EXTPRIO_WMASK);
    end

    // Two flops before any logic looks at a pin
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            pin_prev_q <= '0;
        end
        else
        begin
            pin_meta_q <= ext_irq_pin;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // A pin idling high would look like a rising edge straight after reset
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            settle_q <= 2'h0;
        else if (settle_q != `IPC_SYNC_SETTLE)
            settle_q <= settle_q + 2'h1;
    end

    assign edge_armed = (settle_q == `IPC_SYNC_SETTLE);
    assign pin_rise = pin_sync_q & ~pin_prev_q;
    assign pin_fall = ~pin_sync_q & pin_prev_q;

    // Polarity bit n picks the edge of input n
    always_comb
    begin
        pin_edge = '0;
        for (int n = 0; n < NEXT; n++)
        begin
            if (edge_armed)
                pin_edge[n] = ctrl2_q[n] ? pin_fall[n] : pin_rise[n];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            edge_q <= '0;
        else
            edge_q <= pin_edge;
    end

    // Sticky edge flags, cleared by write-one or by the core taking them
    assign sw_clear = (bus_wr && wb_adr_i == `IPC_OFF_EXTFLAG && wb_sel_i[0])
        ? wb_dat_i[NEXT-1:0] : '0;

    always_comb
    begin
        ack_clear = '0;
        if (cpu_irq_ack && irq_req_q && irq_id_q < 4'(NEXT))
            ack_clear[irq_id_q[2:0]] = 1'b1;
    end

    // New edge wins over a clear in the same cycle
    assign ext_flag_d = (ext_flag_q & ~(sw_clear | ack_clear)) | pin_edge;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            ext_flag_q <= '0;
        else
            ext_flag_q <= ext_flag_d;
    end

    // Arbiter inputs in source id order
    always_comb
    begin
        arb_bus.req = {periph_irq_req, ext_flag_q};
        for (int n = 0; n < NEXT; n++)
            arb_bus.prio[n] = prio_field(extprio_q, n * `IPC_EXTPRIO_STRIDE);
        arb_bus.prio[ipc_pkg::IPC_SRC_SER3_TX] = prio_field(ser3_q, `IPC_SER3_TX_POS);
        arb_bus.prio[ipc_pkg::IPC_SRC_SER3_RX] = prio_field(ser3_q, `IPC_SER3_RX_POS);
        arb_bus.prio[ipc_pkg::IPC_SRC_SER3_ERR] = prio_field(ser3_q, `IPC_SER3_ERR_POS);
        arb_bus.prio[ipc_pkg::IPC_SRC_SPI3_EV] = prio_field(prio20_q, `IPC_P20_SPIEV_POS);
        arb_bus.prio[ipc_pkg::IPC_SRC_SPI3_FLT] = prio_field(prio20_q, `IPC_P20_SPIFLT_POS);
        arb_bus.prio[ipc_pkg::IPC_SRC_SER4_TX] = prio_field(prio20_q, `IPC_P20_U4TX_POS);
        arb_bus.prio[ipc_pkg::IPC_SRC_SER4_RX] = prio_field(prio20_q, `IPC_P20_U4RX_POS);
    end

    // Winner is registered; it may lag a changed request by one cycle
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            irq_req_q <= 1'b0;
            irq_id_q <= 4'h0;
            irq_level_q <= 3'h0;
        end
        else
        begin
            irq_req_q <= arb_bus.win_valid;
            irq_id_q <= arb_bus.win_id;
            irq_level_q <= arb_bus.win_level;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_d = 32'h0;
        case (wb_adr_i)
            `IPC_OFF_CTRL2:
            begin
                rdata_d = ctrl2_q & `IPC_CTRL2_WMASK;
                rdata_d[`IPC_CTRL2_HOLD_BIT] = irq_hold_active;
            end
            `IPC_OFF_SER3:
                rdata_d = ser3_q & `IPC_SER3_WMASK;
            `IPC_OFF_PRIO20:
                rdata_d = prio20_q & `IPC_PRIO20_WMASK;
            `IPC_OFF_EXTPRIO:
                rdata_d = extprio_q & `IPC_EXTPRIO_WMASK;
            `IPC_OFF_EXTFLAG:
                rdata_d[NEXT-1:0] = ext_flag_q;
            `IPC_OFF_PRESENT:
            begin
                rdata_d[`IPC_PRESENT_VALID_BIT] = irq_req_q;
                rdata_d[`IPC_PRESENT_LEVEL_POS +: 3] = irq_level_q;
                rdata_d[3:0] = irq_id_q;
            end
            default:
                rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            rdata_q <= 32'h0;
        else if (bus_rd)
            rdata_q <= rdata_d;
        else if (bus_req)
            rdata_q <= 32'h0;
    end

    // Output drives, all from flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign cpu_irq_req = irq_req_q;
    assign cpu_irq_id = irq_id_q;
    assign cpu_irq_level = irq_level_q;
    assign alternate_vector_select = ctrl2_q[`IPC_CTRL2_ALTVEC_BIT];
    assign ext_irq_edge = edge_q;

endmodule

`default_nettype wire

// ---- bench/ipc_chk_properties.sv ----
// Port-level properties of the priority block
`timescale 1ns/1ps
`default_nettype none

module ipc_chk #(
    parameter int NEXT = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and core side
    input wire logic [NEXT-1:0] ext_irq_pin,
    input wire logic irq_hold_active,
    input wire logic cpu_irq_req,
    input wire logic [3:0] cpu_irq_id,
    input wire logic [2:0] cpu_irq_level,
    input wire logic alternate_vector_select,
    input wire logic [NEXT-1:0] ext_irq_edge
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ctrl_wr;
        wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[1];
    endsequence
    a_ack_timing: assert property (s_take |=> wb_ack_o)
        else $error("bus ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus ack without request");
    a_ctrl_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |->
        wb_dat_o[31:16] == 16'h0 && wb_dat_o[13:5] == 9'h0 &&
        wb_dat_o[14] == $past(irq_hold_active))
        else $error("control read wrong");
    a_alt_write: assert property (s_ctrl_wr |-> alternate_vector_select == wb_dat_i[15])
        else $error("vector select not written");
    a_req_level: assert property (cpu_irq_req |-> cpu_irq_level != 3'h0 && cpu_irq_id <= 4'hB)
        else $error("presented priority zero");
    a_idle_level: assert property (!cpu_irq_req |-> cpu_irq_level == 3'h0)
        else $error("level without request");
    a_edge_cause: assert property (ext_irq_edge != '0 |->
        (ext_irq_edge & ~($past(ext_irq_pin, 1) ^ $past(ext_irq_pin, 6))) == '0)
        else $error("edge pulse without pin change");
    a_edge_pulse: assert property ((ext_irq_edge & $past(ext_irq_edge)) == 0)
        else $error("edge pulse too long");
endmodule

bind ipc_top ipc_chk #(.NEXT(NEXT)) u_chk (.core_clk(core_clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_irq_pin(ext_irq_pin), .irq_hold_active(irq_hold_active), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_id(cpu_irq_id), .cpu_irq_level(cpu_irq_level),
    .alternate_vector_select(alternate_vector_select), .ext_irq_edge(ext_irq_edge));

`default_nettype wire

// ---- bench/ipc_core_model.sv ----
// Core model: acknowledges the presented interrupt after a set delay
`timescale 1ns/1ps
`default_nettype none

module ipc_core_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Bench control
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    // Block side
    input wire logic cpu_irq_req,
    output logic cpu_irq_ack
);
    logic [3:0] wait_q;
    // Count restarts after each ack so a stale request is not acked twice
    always_ff @(posedge core_clk)
    begin
        if (!resetn || !ack_en || !cpu_irq_req || cpu_irq_ack)
        begin
            wait_q <= 4'h0;
            cpu_irq_ack <= 1'b0;
        end
        else if (wait_q == ack_delay)
            cpu_irq_ack <= 1'b1;
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench of the priority block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [4:0] pins = 5'h00;
    logic [6:0] preq = 7'h00;
    logic hold = 1'b0;
    logic ack_en = 1'b0;
    logic [31:0] rdat, rd;
    logic ack, cpu_ack, irq_req, alt;
    logic [3:0] irq_id;
    logic [2:0] irq_lvl;
    logic [4:0] edges, seen;
    int failures = 0;
    int n_compared = 0;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rst_v [7] = '{32'h0, 32'h4440, 32'h4444, 32'h44444, 32'h0, 32'h0, 32'h0};
    logic [31:0] all_v [7] = '{32'h801F, 32'h7770, 32'h7777, 32'h77777, 32'h0, 32'h0, 32'h0};
    logic [6:0] pat [5] = '{7'h02, 7'h05, 7'h0F, 7'h60, 7'h12};
    logic [3:0] e_rl [5] = '{4'h0, 4'hD, 4'hF, 4'hB, 4'h0};
    logic [3:0] e_id [5] = '{4'h0, 4'h7, 4'h8, 4'hA, 4'h0};

    initial forever #2.5 core_clk = ~core_clk;

    ipc_top dut (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_irq_pin(pins), .periph_irq_req(preq), .irq_hold_active(hold),
        .cpu_irq_ack(cpu_ack), .cpu_irq_req(irq_req), .cpu_irq_id(irq_id),
        .cpu_irq_level(irq_lvl), .alternate_vector_select(alt), .ext_irq_edge(edges));

    ipc_core_model core (.core_clk(core_clk), .resetn(resetn), .ack_en(ack_en),
        .ack_delay(4'h2), .cpu_irq_req(irq_req), .cpu_irq_ack(cpu_ack));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge core_clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do @(posedge core_clk); while (ack !== 1'b1 && ++n < 20);
        chk("bus ack", 32'h1, {31'h0, ack});
        rd = rdat;
        {cyc, stb} <= 2'b00;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'hF);
        chk($sformatf("register %h", a), exp, rd);
    endtask

    task automatic catch_edges(input logic [4:0] p);
        seen = 5'h00;
        pins <= p;
        repeat (10)
        begin
            @(posedge core_clk);
            seen = seen | edges;
        end
    endtask

    task automatic final_report;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        final_report();
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        foreach (offs[i]) rchk(offs[i], rst_v[i]);
        foreach (offs[i]) xfer(1'b1, offs[i], 32'hFFFFFFFF, 4'hF);
        foreach (offs[i]) rchk(offs[i], all_v[i]);
        xfer(1'b1, 8'h00, 32'h0, 4'h1);
        chk("vector select set", 32'h1, {31'h0, alt});
        hold <= 1'b1;
        rchk(8'h00, 32'hC000);
        hold <= 1'b0;
        xfer(1'b1, 8'h00, 32'h0000000A, 4'hF);
        chk("vector select clear", 32'h0, {31'h0, alt});
        catch_edges(5'h1F);
        chk("rising edges", 32'h15, {27'h0, seen});
        catch_edges(5'h00);
        chk("falling edges", 32'h0A, {27'h0, seen});
        rchk(8'h10, 32'h1F);
        rchk(8'h14, 32'h170);
        // Write-one clear of two flags leaves the others pending
        xfer(1'b1, 8'h10, 32'h00000005, 4'hF);
        rchk(8'h10, 32'h1A);
        ack_en <= 1'b1;
        repeat (40) @(posedge core_clk);
        ack_en <= 1'b0;
        rchk(8'h10, 32'h0);
        xfer(1'b1, 8'h0C, 32'h0, 4'hF);
        xfer(1'b1, 8'h04, 32'h2050, 4'hF);
        xfer(1'b1, 8'h08, 32'h7033, 4'hF);
        foreach (pat[i])
        begin
            preq <= pat[i];
            repeat (3) @(posedge core_clk);
            chk("request and level", {28'h0, e_rl[i]}, {28'h0, irq_req, irq_lvl});
            if (e_rl[i][3])
                chk("winner", {28'h0, e_id[i]}, {28'h0, irq_id});
        end
        // Mid-run reset: priorities fall back to four, pending levels still compete
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        rchk(8'h08, 32'h4444);
        rchk(8'h14, 32'h146);
        final_report();
    end
endmodule

`default_nettype wire
